// ==== hw/ccf_cfg.svh ====
// Constants for the condition flag block: flag bit positions, widths, reset value.
// Assumes inclusion by bare name from design files.
`ifndef CCF_CFG_SVH
`define CCF_CFG_SVH
`define CCF_FLAG_C_POS 0
`define CCF_FLAG_V_POS 1
`define CCF_FLAG_Z_POS 2
`define CCF_FLAG_N_POS 3
`define CCF_WORD_MSB 15
`define CCF_BYTE_MSB 7
`define CCF_FLAGS_RESET 4'h0
`endif

// ==== hw/ccf_pkg.sv ====
// Types for the condition flag block.
// Assumes ccf_cfg.svh is on the include path.
package ccf_pkg;
   // Operation class presented with each result
   typedef enum logic [3:0]
   {
      ccf_op_none,
      ccf_op_add,
      ccf_op_sub,
      ccf_op_compare_op,
      ccf_op_inc,
      ccf_op_minus_one_op,
      ccf_op_sign_invert_op,
      ccf_op_shift_left,
      ccf_op_shift_right,
      ccf_op_rotate_left_op,
      ccf_op_rotate_right_op,
      ccf_op_ones_invert_op,
      ccf_op_zero_sign_test_op,
      ccf_op_logic,
      ccf_op_zero_store_op,
      ccf_op_move
   } ccf_op_t;
endpackage

// ==== hw/ccf_shift_unit.sv ====
// Shift and rotate datapath: computes result and bit shifted out.
// Assumes purely combinational use by ccf_flag_logic.
`timescale 1ns/1ps
module ccf_shift_unit
   import ccf_pkg::*;
#(
   parameter int WIDTH = 16
)
(
   // Operand and control
   input wire logic [WIDTH-1:0] operand,
   input wire logic byte_mode,
   input wire logic carry_in,
   input wire logic dir_left,
   input wire logic rotate,
   // Result
   output logic [WIDTH-1:0] result,
   output logic carry_out
);
   initial
   begin
      if (WIDTH != 16)
      begin
         $error("ccf_shift_unit supports WIDTH 16 only");
      end
   end

   logic fill_bit;

   always_comb
   begin
      result = operand;
      carry_out = 1'b0;
      fill_bit = 1'b0;
      if (dir_left)
      begin
         fill_bit = rotate ? carry_in : 1'b0;
         if (byte_mode)
         begin
            carry_out = operand[7];
            result = {operand[15:8], operand[6:0], fill_bit};
         end
         else
         begin
            carry_out = operand[15];
            result = {operand[14:0], fill_bit};
         end
      end
      else
      begin
         carry_out = operand[0];
         if (byte_mode)
         begin
            fill_bit = rotate ? carry_in : operand[7];
            result = {operand[15:8], fill_bit, operand[7:1]};
         end
         else
         begin
            fill_bit = rotate ? carry_in : operand[15];
            result = {fill_bit, operand[15:1]};
         end
      end
   end
endmodule

// ==== hw/ccf_sign_pick.sv ====
// Selects sign bit and zero test of a result by byte or word width.
// Assumes combinational use.
`timescale 1ns/1ps
`include "ccf_cfg.svh"
module ccf_sign_pick
   import ccf_pkg::*;
#(
   parameter int WIDTH = 16
)
(
   // Value and width
   input wire logic [WIDTH-1:0] value,
   input wire logic byte_mode,
   // Derived
   output logic sign,
   output logic is_zero
);
   initial
   begin
      if (WIDTH != 16)
      begin
         $error("ccf_sign_pick supports WIDTH 16 only");
      end
   end

   always_comb
   begin
      sign = byte_mode ? value[`CCF_BYTE_MSB] : value[`CCF_WORD_MSB];
      is_zero = byte_mode ? (value[`CCF_BYTE_MSB:0] == 8'h00) : (value == 16'h0000);
   end
endmodule

// ==== hw/ccf_flag_logic.sv ====
// Condition flag logic: derives negative, zero, overflow and carry from each result
// and holds them in the flag field of the processor status word.
// Assumes operands and op class come from the ALU on mclk, one instruction per strobe.
// Notes on behaviour
// - Four flags N Z V C held in status word, 1 means true.
// - N takes result sign bit even when overflow makes it untrue.
// - Z set when result is zero, cleared otherwise.
// - Single-operand arithmetic: V set when the sign changes in the counting direction, or when negating a negative value leaves a negative result.
// - Add: V when operands share sign and result differs; subtract, compare: V when operand signs differ and result differs.
// - Shifts and rotates: V equals new N xor new C.
// - Add: C takes carry out of result top bit, else cleared; increment and decrement keep C.
// - Rotates pass through C between top and bottom bits.
// - Subtract and compare set C when no carry, marking a borrow.
// - Logical operations leave C unchanged.
// - Ones complement always sets C, test always clears C.
// - Flags update each instruction, except when a register write to the flags in the same cycle wins; unaffected flags keep value.
// - Stored flags are presented for branch decisions.
// - Byte-mode instructions derive flags from the byte result.
`timescale 1ns/1ps
`include "ccf_cfg.svh"
module ccf_flag_logic
   import ccf_pkg::*;
#(
   parameter int WIDTH = 16
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   input wire logic clk_en,
   // Instruction result from ALU
   input wire logic op_valid,
   input wire ccf_op_t op_class,
   input wire logic byte_mode,
   input wire logic [WIDTH-1:0] src_operand,
   input wire logic [WIDTH-1:0] dst_operand,
   // Direct flag load for set or clear condition code operations
   input wire logic flag_load,
   input wire logic flag_set,
   input wire logic [3:0] flag_select,
   // Register port
   input wire logic [1:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // Result and flags
   output logic [WIDTH-1:0] result,
   output logic flag_n,
   output logic flag_z,
   output logic flag_v,
   output logic flag_c,
   output logic [3:0] processor_status_word
);
   initial
   begin
      if (WIDTH != 16)
      begin
         $error("ccf_flag_logic supports WIDTH 16 only");
      end
   end

   localparam logic [1:0] REG_FLAGS = 2'h0;
   localparam logic [1:0] REG_RESULT = 2'h1;

   ////////////////////////////////////////////////////////////////////////////////
   // Arithmetic

   logic [3:0] flags_ff;
   logic [3:0] nxt_flags;
   logic [WIDTH-1:0] result_ff;
   logic [WIDTH-1:0] nxt_result;
   logic [15:0] rdata_ff;
   logic [15:0] nxt_rdata;
   logic [WIDTH:0] sum_word;
   logic [8:0] sum_byte;
   logic [WIDTH-1:0] add_b;
   logic add_cin;
   logic [WIDTH-1:0] alu_val;
   logic alu_carry;
   logic sh_left;
   logic sh_rot;
   logic [WIDTH-1:0] sh_val;
   logic sh_carry;
   logic res_sign;
   logic res_zero;
   logic src_sign;
   logic dst_sign;

   always_comb
   begin
      add_b = src_operand;
      add_cin = 1'b0;
      unique case (op_class)
         ccf_op_sub, ccf_op_compare_op:
         begin
            add_b = ~src_operand;
            add_cin = 1'b1;
         end
         ccf_op_inc:
         begin
            add_b = 16'h0001;
         end
         ccf_op_minus_one_op:
         begin
            add_b = 16'hFFFF;
         end
         default:
         begin
            add_b = src_operand;
         end
      endcase
      sum_word = {1'b0, dst_operand} + {1'b0, add_b} + {16'h0000, add_cin};
      sum_byte = {1'b0, dst_operand[7:0]} + {1'b0, add_b[7:0]} + {8'h00, add_cin};
   end

   always_comb
   begin
      sh_left = (op_class == ccf_op_shift_left) || (op_class == ccf_op_rotate_left_op);
      sh_rot = (op_class == ccf_op_rotate_left_op) || (op_class == ccf_op_rotate_right_op);
   end

   ccf_shift_unit #(.WIDTH(WIDTH)) u_shift
   (
      .operand(dst_operand),
      .byte_mode(byte_mode),
      .carry_in(flags_ff[`CCF_FLAG_C_POS]),
      .dir_left(sh_left),
      .rotate(sh_rot),
      .result(sh_val),
      .carry_out(sh_carry)
   );

   always_comb
   begin
      alu_val = dst_operand;
      alu_carry = byte_mode ? sum_byte[8] : sum_word[WIDTH];
      unique case (op_class)
         ccf_op_add, ccf_op_sub, ccf_op_compare_op, ccf_op_inc, ccf_op_minus_one_op:
         begin
            alu_val = sum_word[WIDTH-1:0];
         end
         ccf_op_sign_invert_op:
         begin
            alu_val = 16'h0000 - dst_operand;
            alu_carry = byte_mode ? (dst_operand[7:0] != 8'h00) : (dst_operand != 16'h0000);
         end
         ccf_op_ones_invert_op:
         begin
            alu_val = ~dst_operand;
         end
         ccf_op_logic:
         begin
            alu_val = src_operand & dst_operand;
         end
         ccf_op_zero_store_op:
         begin
            alu_val = 16'h0000;
         end
         ccf_op_move:
         begin
            alu_val = src_operand;
         end
         ccf_op_shift_left, ccf_op_shift_right, ccf_op_rotate_left_op,
         ccf_op_rotate_right_op:
         begin
            alu_val = sh_val;
            alu_carry = sh_carry;
         end
         default:
         begin
            alu_val = dst_operand;
         end
      endcase
   end

   ccf_sign_pick #(.WIDTH(WIDTH)) u_res_sign
   (
      .value(alu_val),
      .byte_mode(byte_mode),
      .sign(res_sign),
      .is_zero(res_zero)
   );

   ccf_sign_pick #(.WIDTH(WIDTH)) u_src_sign
   (
      .value(src_operand),
      .byte_mode(byte_mode),
      .sign(src_sign),
      .is_zero()
   );

   ccf_sign_pick #(.WIDTH(WIDTH)) u_dst_sign
   (
      .value(dst_operand),
      .byte_mode(byte_mode),
      .sign(dst_sign),
      .is_zero()
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Flag update

   always_comb
   begin
      nxt_flags = flags_ff;
      nxt_result = result_ff;
      if (op_valid && (op_class != ccf_op_none))
      begin
         if (op_class != ccf_op_compare_op && op_class != ccf_op_zero_sign_test_op
             && op_class != ccf_op_logic)
         begin
            nxt_result = alu_val;
         end
         nxt_flags[`CCF_FLAG_N_POS] = res_sign;
         nxt_flags[`CCF_FLAG_Z_POS] = res_zero;
         nxt_flags[`CCF_FLAG_V_POS] = 1'b0;
         unique case (op_class)
            ccf_op_add:
            begin
               nxt_flags[`CCF_FLAG_V_POS] = (src_sign == dst_sign) &&
                  (res_sign != dst_sign);
               nxt_flags[`CCF_FLAG_C_POS] = alu_carry;
            end
            ccf_op_sub, ccf_op_compare_op:
            begin
               // Sign of subtrahend is inverted in the adder, so compare against it
               nxt_flags[`CCF_FLAG_V_POS] = (src_sign != dst_sign) &&
                  (res_sign != dst_sign);
               nxt_flags[`CCF_FLAG_C_POS] = ~alu_carry;
            end
            ccf_op_inc, ccf_op_minus_one_op, ccf_op_sign_invert_op:
            begin
               if (op_class == ccf_op_sign_invert_op)
               begin
                  // Negating the most negative value leaves it negative
                  nxt_flags[`CCF_FLAG_V_POS] = res_sign && dst_sign;
                  nxt_flags[`CCF_FLAG_C_POS] = alu_carry;
               end
               else
               begin
                  // Only a sign change in the counting direction overflows
                  nxt_flags[`CCF_FLAG_V_POS] = (res_sign != dst_sign) &&
                     (op_class == ccf_op_inc ? res_sign : dst_sign);
               end
            end
            ccf_op_shift_left, ccf_op_shift_right, ccf_op_rotate_left_op,
            ccf_op_rotate_right_op:
            begin
               nxt_flags[`CCF_FLAG_C_POS] = alu_carry;
               nxt_flags[`CCF_FLAG_V_POS] = res_sign ^ alu_carry;
            end
            ccf_op_ones_invert_op:
            begin
               nxt_flags[`CCF_FLAG_C_POS] = 1'b1;
            end
            ccf_op_zero_sign_test_op, ccf_op_zero_store_op:
            begin
               nxt_flags[`CCF_FLAG_C_POS] = 1'b0;
            end
            default:
            begin
               // Logic and move keep carry
               nxt_flags[`CCF_FLAG_C_POS] = flags_ff[`CCF_FLAG_C_POS];
            end
         endcase
      end
      else if (flag_load)
      begin
         nxt_flags = flag_set ? (flags_ff | flag_select) : (flags_ff & ~flag_select);
      end
      if (reg_wr && reg_addr == REG_FLAGS)
      begin
         nxt_flags = reg_wdata[3:0];
      end
   end

   always_comb
   begin
      nxt_rdata = 16'h0000;
      if (reg_rd)
      begin
         unique case (reg_addr)
            REG_FLAGS: nxt_rdata = {12'h000, flags_ff};
            REG_RESULT: nxt_rdata = result_ff;
            default: nxt_rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         flags_ff <= `CCF_FLAGS_RESET;
         result_ff <= 16'h0000;
         rdata_ff <= 16'h0000;
      end
      else if (clk_en)
      begin
         flags_ff <= nxt_flags;
         result_ff <= nxt_result;
         rdata_ff <= nxt_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs for branch logic

   always_comb
   begin
      processor_status_word = flags_ff;
      flag_n = flags_ff[`CCF_FLAG_N_POS];
      flag_z = flags_ff[`CCF_FLAG_Z_POS];
      flag_v = flags_ff[`CCF_FLAG_V_POS];
      flag_c = flags_ff[`CCF_FLAG_C_POS];
      result = result_ff;
      reg_rdata = rdata_ff;
   end
endmodule

// ==== bench/ccf_flag_logic_sva.sv ====
// Checker for the condition flag block: flags against results and inputs.
// Assumes one clock mclk and asynchronous reset rst, bound to ccf_flag_logic.
`timescale 1ns/1ps
module ccf_flag_logic_sva
   import ccf_pkg::*;
#(
   parameter int WIDTH = 16
)
(
   // Clock and control
   input wire logic mclk,
   input wire logic rst,
   input wire logic clk_en,
   // Instruction and loads
   input wire logic op_valid,
   input wire ccf_op_t op_class,
   input wire logic byte_mode,
   input wire logic [WIDTH-1:0] dst_operand,
   input wire logic flag_load,
   // Register port
   input wire logic [1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   // Outputs
   input wire logic [WIDTH-1:0] result,
   input wire logic flag_n,
   input wire logic flag_z,
   input wire logic flag_v,
   input wire logic flag_c,
   input wire logic [3:0] processor_status_word
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   logic go;
   assign go = clk_en && op_valid && !reg_wr;
   psw_pack_a: assert property (
      processor_status_word == {flag_n, flag_z, flag_v, flag_c})
      else $error("status word differs from flags");
   flags_hold_a: assert property ((!clk_en || !(op_valid || flag_load || reg_wr))
      |=> $stable(processor_status_word)) else $error("flags moved while idle");
   zero_store_a: assert property (go && op_class == ccf_op_zero_store_op
      |=> flag_z && !flag_n && !flag_v && !flag_c) else $error("clear op flags wrong");
   invert_carry_a: assert property (go && op_class == ccf_op_ones_invert_op
      |=> flag_c && !flag_v) else $error("invert op carry wrong");
   test_carry_a: assert property (go && op_class == ccf_op_zero_sign_test_op
      |=> !flag_c) else $error("test op carry wrong");
   logic_carry_a: assert property (go && op_class == ccf_op_logic |=> $stable(flag_c))
      else $error("logic op changed carry");
   shift_ovf_a: assert property (go && op_class inside {ccf_op_shift_left,
      ccf_op_shift_right, ccf_op_rotate_left_op, ccf_op_rotate_right_op}
      |=> flag_v == (flag_n ^ flag_c)) else $error("shift overflow wrong");
   sign_zero_a: assert property (go && !byte_mode && op_class inside {
      ccf_op_add, ccf_op_sub, ccf_op_inc, ccf_op_minus_one_op}
      |=> flag_n == result[WIDTH-1] && flag_z == (result == '0)) else $error("sign or zero wrong");
   rot_carry_a: assert property (go && !byte_mode && op_class == ccf_op_rotate_left_op
      |=> flag_c == $past(dst_operand[WIDTH-1])) else $error("rotate carry wrong");
   read_flags_a: assert property (clk_en && reg_rd && reg_addr == 2'h0
      |=> reg_rdata == {12'h000, $past(processor_status_word)}) else $error("flag read wrong");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind ccf_flag_logic ccf_flag_logic_sva #(.WIDTH(WIDTH)) u_sva (.mclk, .rst, .clk_en,
   .op_valid, .op_class, .byte_mode, .dst_operand, .flag_load, .reg_addr, .reg_wr, .reg_rd,
   .reg_rdata, .result, .flag_n, .flag_z, .flag_v, .flag_c, .processor_status_word);

// ==== bench/test_ccf_flag_logic.sv ====
// Self-checking bench: random instructions, flag loads and register accesses
// compared every cycle with a behavioural flag model.
// Assumes the design package and ccf_cfg.svh are compiled first.
`timescale 1ns/1ps
module test_ccf_flag_logic;
   import ccf_pkg::*;
   logic mclk, rst, clk_en, op_valid, byte_mode, flag_load, flag_set, reg_wr, reg_rd;
   logic flag_n, flag_z, flag_v, flag_c, res_ok, rd_ok;
   ccf_op_t op_class;
   logic [15:0] src_operand, dst_operand, reg_wdata, reg_rdata, result, er, erd, s, d;
   logic [3:0] flag_select, processor_status_word, ef;
   logic [1:0] reg_addr;
   int num_errors, checks_done, seed, i, p, k, j;
   ccf_flag_logic #(.WIDTH(16)) DUT (.mclk, .rst, .clk_en, .op_valid, .op_class, .byte_mode,
      .src_operand, .dst_operand, .flag_load, .flag_set, .flag_select, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .result, .flag_n, .flag_z, .flag_v, .flag_c,
      .processor_status_word);
   initial
   begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic model(input ccf_op_t op, input logic bm, input logic [15:0] s, d);
      logic [16:0] w;
      logic [15:0] m, sb, r, hi;
      logic c, v, n, wr, sd, sh;
      m = bm ? 16'h00ff : 16'hffff;
      sb = bm ? 16'h0080 : 16'h8000;
      hi = d & ~m;
      sd = |(d & sb);
      {c, v, wr, sh, r} = {ef[0], 1'b0, 1'b1, 1'b0, d};
      case (op)
         ccf_op_none: return;
         ccf_op_add:
         begin
            w = {1'b0, d & m} + {1'b0, s & m};
            r = d + s;
            c = bm ? w[8] : w[16];
            v = (sd == |(s & sb)) && (sd != |(r & sb));
         end
         ccf_op_sub, ccf_op_compare_op:
         begin
            w = {1'b0, d & m} - {1'b0, s & m};
            r = d - s;
            c = bm ? w[8] : w[16];
            v = (sd != |(s & sb)) && (sd != |(r & sb));
            wr = op == ccf_op_sub;
         end
         ccf_op_inc:
         begin
            r = d + 16'h0001;
            v = (r & m) == sb;
         end
         ccf_op_minus_one_op:
         begin
            r = d - 16'h0001;
            v = (d & m) == sb;
         end
         ccf_op_sign_invert_op:
         begin
            r = -d;
            c = (r & m) != 16'h0000;
            v = (r & m) == sb;
         end
         ccf_op_shift_left, ccf_op_rotate_left_op:
         begin
            r = hi | (((d << 1) | {15'h0000, ef[0] & (op != ccf_op_shift_left)}) & m);
            {c, sh} = {sd, 1'b1};
         end
         ccf_op_shift_right, ccf_op_rotate_right_op:
         begin
            r = hi | ((d & m) >> 1) |
               (op == ccf_op_shift_right ? d & sb : (ef[0] ? sb : 16'h0000));
            {c, sh} = {d[0], 1'b1};
         end
         ccf_op_ones_invert_op: {r, c} = {~d, 1'b1};
         ccf_op_zero_sign_test_op: {wr, c} = 2'b00;
         ccf_op_logic: {r, wr} = {s & d, 1'b0};
         ccf_op_zero_store_op: {r, c} = 17'h0_0000;
         default: r = s;
      endcase
      n = |(r & sb);
      ef = {n, (r & m) == 16'h0000, sh ? n ^ c : v, c};
      if (wr)
      begin
         er = r;
         res_ok = 1'b1;
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {seed, num_errors, checks_done} = {32'd26134, 64'd0};
      {clk_en, byte_mode, flag_set} = '0;
      op_class = ccf_op_none;
      {src_operand, dst_operand, reg_wdata, flag_select, reg_addr} = '0;
      for (p = 0; p < 2; p++)
      begin
         rst <= 1'b1;
         {op_valid, flag_load, reg_wr, reg_rd} <= 4'h0;
         {ef, er, erd, res_ok, rd_ok} = {36'h0_0000_0000, 2'b11};
         repeat (p ? 3 : 8) @(posedge mclk);
         rst <= 1'b0;
         for (i = 0; i < 3000; i++)
         begin
            @(posedge mclk);
            k = $unsigned($random(seed)) % 8;
            j = $random(seed);
            d = $random(seed);
            s = $random(seed);
            if (j[1:0] == 2'h0) d = 16'h7ffe + 16'(j[3:2]);
            if (j[1:0] == 2'h1) d = 16'h007e + 16'(j[3:2]);
            if (j[4] || j[8:5] inside {ccf_op_logic, ccf_op_move}) s = d;
            op_valid <= k < 5;
            flag_load <= k == 5;
            reg_wr <= k == 6;
            reg_rd <= k == 7;
            clk_en <= k > 4 || j[12:9] != 4'h0;
            op_class <= ccf_op_t'(j[8:5]);
            byte_mode <= j[13];
            {src_operand, dst_operand, reg_wdata} <= {s, d, s};
            {flag_set, flag_select, reg_addr} <= j[21:15];
            #1;
            check({12'h000, flag_n, flag_z, flag_v, flag_c}, {12'h000, ef});
            if (res_ok) check(result, er);
            if (rd_ok) check(reg_rdata, erd);
            rd_ok = clk_en && !(reg_rd && reg_addr == 2'h1 && !res_ok);
            erd = 16'h0000;
            if (clk_en)
            begin
               if (reg_rd)
                  erd = reg_addr == 2'h0 ? {12'h000, ef} : reg_addr == 2'h1 ? er : 16'h0000;
               if (reg_wr && reg_addr == 2'h0) ef = reg_wdata[3:0];
               if (flag_load) ef = flag_set ? ef | flag_select : ef & ~flag_select;
               if (op_valid) model(op_class, byte_mode, src_operand, dst_operand);
            end
         end
         $display("pass %0d done: %0d checks, %0d mismatches", p, checks_done, num_errors);
      end
      report_and_stop();
   end
endmodule
